// *** hw/ffs_flag_core.v ***
// Purpose: Offset registers and status flags of a clocked FIFO.
// Assumes: Write and read clock pins are sampled on CLK as events.
// Notes: RAM sits outside; writes leave through a two-entry buffer.
//
// Operation
// - Offsets load from low twelve data bits with load and write low.
// - First loading write edge stores the empty offset.
// - Further loading edges alternate full, empty, full offsets.
// - Load high resumes normal work; next load continues alternation.
// - Load and read low present empty then full offset on outputs.
// - Offset readback only in standard mode, never in fall-through.
// - Strap selects asynchronous or synchronous partial-flag timing.
// - Async: almost-empty set on read edge, cleared on write edge.
// - Async: almost-full set on write edge, cleared on read edge.
// - Sync: almost-empty changes only on read edges.
// - Sync: almost-full changes only on write edges.
// - Buffering stages apply only to empty and full flags.
// - Each extra buffer stage adds one edge of flag delay.
// - Standard mode flag thresholds from word count and offsets.
// - Fall-through thresholds with capacity of depth plus one.
// - Default empty offset 31, 63 or 127 by depth.
// - Default full offset 31, 63 or 127 by depth.
// - Reset restores default offsets and clears the output word.
// - Straps pick partial timing, mode and buffering at reset.
`include "ffs_map.vh"
`default_nettype none

module ffs_flag_core #(
  parameter [`FFS_CNT_W-1:0] DEPTH = `FFS_DEPTH_DEF,
  parameter ADDR_W = `FFS_ADDR_W_DEF
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Write port pins
  input wire WCLK_PIN,
  input wire WRITE_EN_N,
  input wire [`FFS_DATA_W-1:0] DATA_IN,
  // Read port pins
  input wire RCLK_PIN,
  input wire READ_EN_N,
  // Offset load and reset straps
  input wire OFFSET_LOAD_N,
  input wire FIRST_LOAD_SEL,
  input wire READ_CHAIN_IN,
  input wire WRITE_CHAIN_IN,
  // External RAM side
  input wire RAM_WR_READY,
  input wire [`FFS_DATA_W-1:0] RAM_RD_DATA,
  output wire RAM_WR_VALID,
  output wire [`FFS_DATA_W-1:0] RAM_WR_DATA,
  output reg [ADDR_W-1:0] RAM_RD_ADDR,
  // Data and flags
  output reg [`FFS_DATA_W-1:0] DATA_OUT,
  output reg EMPTY_N,
  output reg FULL_N,
  output reg ALMOST_EMPTY_N,
  output reg ALMOST_FULL_N,
  output reg HALF_FULL_N,
  output reg FALL_THROUGH_MODE
);

  ////////////////////////////////////////////////////////////////////////
  // Depth-derived constants
  // empty and full default
  localparam [`FFS_OFS_W-1:0] DEF_OFS =
    (DEPTH == `FFS_DEPTH_256) ? `FFS_OFS_256 :
    (DEPTH == `FFS_DEPTH_512) ? `FFS_OFS_512 : `FFS_OFS_BIG;
  localparam [`FFS_CNT_W-1:0] ONE = 13'h0001;
  localparam [`FFS_CNT_W-1:0] TWO = 13'h0002;
  localparam [`FFS_CNT_W-1:0] HALF = DEPTH >> 1;
  localparam [`FFS_CNT_W-1:0] LAST = DEPTH - ONE;
  localparam [`FFS_CNT_W-1:0] DEP1 = DEPTH + ONE;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one is read only by stage two
  localparam SW = `FFS_DATA_W + 8;
  reg [SW-1:0] pin_s1;
  reg [SW-1:0] pin_s2;
  reg wclk_s3;
  reg rclk_s3;
  // Both clock pins ride in the same vector so their delays match
  wire [SW-1:0] pins = {DATA_IN, WRITE_CHAIN_IN, READ_CHAIN_IN,
    FIRST_LOAD_SEL, OFFSET_LOAD_N, READ_EN_N, WRITE_EN_N, RCLK_PIN, WCLK_PIN};

  // Two flops for every pin, a third on the clock pins for edges
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1 <= {SW{1'b0}};
      pin_s2 <= {SW{1'b0}};
      wclk_s3 <= 1'b0;
      rclk_s3 <= 1'b0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      wclk_s3 <= pin_s2[0];
      rclk_s3 <= pin_s2[1];
    end
  end

  wire wen_n = pin_s2[2];
  wire ren_n = pin_s2[3];
  wire ld_n = pin_s2[4];
  wire fl_s = pin_s2[5];
  wire rxi_s = pin_s2[6];
  wire wxi_s = pin_s2[7];
  wire [`FFS_DATA_W-1:0] din = pin_s2[SW-1:8];

  ////////////////////////////////////////////////////////////////////////
  // Configuration taken a few cycles after reset release
  reg [1:0] cfg_cnt;
  reg cfg_ok;
  reg sync_pf;
  reg fall_through_mode;
  reg [1:0] ef_stg;
  reg [1:0] ff_stg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_cnt <= 2'h0;
      cfg_ok <= 1'b0;
      sync_pf <= 1'b0;
      fall_through_mode <= 1'b0;
      ef_stg <= `FFS_STG_1;
      ff_stg <= `FFS_STG_1;
    end else if (!cfg_ok) begin
      cfg_cnt <= cfg_cnt + 2'h1;
      if (cfg_cnt == `FFS_CFG_WAIT) begin
        cfg_ok <= 1'b1;
        sync_pf <= fl_s;
        fall_through_mode <= ~rxi_s & wxi_s;
        case ({rxi_s, wxi_s})
          2'b01: begin
            ef_stg <= `FFS_STG_3;
            ff_stg <= `FFS_STG_2;
          end
          2'b10: begin
            ef_stg <= `FFS_STG_2;
            ff_stg <= `FFS_STG_2;
          end
          default: begin
            ef_stg <= `FFS_STG_1;
            ff_stg <= `FFS_STG_1;
          end
        endcase
      end
    end
  end

  // Edge events, ignored until the straps have been taken
  wire w_edge = cfg_ok & pin_s2[0] & ~wclk_s3;
  wire r_edge = cfg_ok & pin_s2[1] & ~rclk_s3;

  ////////////////////////////////////////////////////////////////////////
  // Word count and capacity
  reg [`FFS_CNT_W-1:0] cnt;
  reg [`FFS_OFS_W-1:0] empty_offset;
  reg [`FFS_OFS_W-1:0] full_offset;
  wire [`FFS_CNT_W-1:0] cap = fall_through_mode ? DEP1 : DEPTH;
  wire buf_rdy;
  wire wr_take;
  wire rd_take;

  assign wr_take = w_edge & ld_n & ~wen_n & (cnt != cap) & buf_rdy;
  assign rd_take = r_edge & ld_n & ~ren_n & (cnt != 13'h0000);
  // Flags judge the count after this event, so they move with it
  wire [`FFS_CNT_W-1:0] next_cnt = (wr_take == rd_take) ? cnt :
    wr_take ? cnt + ONE : cnt - ONE;

  // Count moves only on true writes and reads, both may coincide
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 13'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Stall by the RAM side fills the buffer, then refuses writes
  ffs_buf2 #(
    .W(`FFS_DATA_W)
  ) u_wbuf (
    .CLK(CLK),
    .RST_N(RST_N),
    .in_valid(wr_take),
    .in_data(din),
    .in_ready(buf_rdy),
    .out_valid(RAM_WR_VALID),
    .out_data(RAM_WR_DATA),
    .out_ready(RAM_WR_READY)
  );

  ////////////////////////////////////////////////////////////////////////
  // Offset registers and their write alternation
  reg ld_sel;
  reg rb_sel;
  wire ld_wr = w_edge & ~ld_n & ~wen_n;
  wire rb_rd = r_edge & ~ld_n & ~ren_n;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      empty_offset <= DEF_OFS;
      full_offset <= DEF_OFS;
      ld_sel <= 1'b0;
    end else if (ld_wr) begin
      ld_sel <= ~ld_sel;
      if (ld_sel) begin
        full_offset <= din[`FFS_OFS_W-1:0];
      end else begin
        empty_offset <= din[`FFS_OFS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word: RAM data on reads, offsets on readback
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_OUT <= {`FFS_DATA_W{1'b0}};
      RAM_RD_ADDR <= {ADDR_W{1'b0}};
      rb_sel <= 1'b0;
    end else if (rb_rd) begin
      if (!fall_through_mode) begin
        rb_sel <= ~rb_sel;
        DATA_OUT <= {6'h00, rb_sel ? full_offset : empty_offset};
      end
    end else if (rd_take) begin
      DATA_OUT <= RAM_RD_DATA;
      if (RAM_RD_ADDR == LAST[ADDR_W-1:0]) begin
        RAM_RD_ADDR <= {ADDR_W{1'b0}};
      end else begin
        RAM_RD_ADDR <= RAM_RD_ADDR + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Raw flag conditions from the count, true means condition holds
  wire [`FFS_CNT_W-1:0] n13 = {1'b0, empty_offset};
  wire [`FFS_CNT_W-1:0] m13 = {1'b0, full_offset};
  reg empty_raw;
  reg full_raw;
  reg ae_raw;
  reg hf_raw;
  reg af_raw;

  // Thresholds other than empty differ by one word between the two modes
  always @* begin
    empty_raw = (next_cnt == 13'h0000);
    if (fall_through_mode) begin
      full_raw = (next_cnt == DEP1);
      ae_raw = (next_cnt <= n13 + ONE);
      hf_raw = (next_cnt >= HALF + TWO);
      af_raw = (next_cnt >= DEP1 - m13);
    end else begin
      full_raw = (next_cnt == DEPTH);
      ae_raw = (next_cnt <= n13);
      hf_raw = (next_cnt > HALF);
      af_raw = (next_cnt >= DEPTH - m13);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boundary flag pipelines; more stages trade latency for stability
  reg ef_p0;
  reg ef_p1;
  reg ff_p0;
  reg next_ef;
  reg next_ff;

  always @* begin
    case (ef_stg)
      `FFS_STG_3: next_ef = ef_p1;
      `FFS_STG_2: next_ef = ef_p0;
      default: next_ef = empty_raw;
    endcase
    case (ff_stg)
      `FFS_STG_2: next_ff = ff_p0;
      default: next_ff = full_raw;
    endcase
  end

  // Empty side moves on read edges, full side on write edges
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ef_p0 <= 1'b1;
      ef_p1 <= 1'b1;
      ff_p0 <= 1'b0;
      EMPTY_N <= 1'b0;
      FULL_N <= 1'b1;
      FALL_THROUGH_MODE <= 1'b0;
    end else if (!cfg_ok) begin
      // Mode sets pin polarity: ready flags are active low
      FALL_THROUGH_MODE <= ~rxi_s & wxi_s;
    end else begin
      if (r_edge) begin
        ef_p0 <= empty_raw;
        ef_p1 <= ef_p0;
        EMPTY_N <= fall_through_mode ? next_ef : ~next_ef;
      end
      if (w_edge) begin
        ff_p0 <= full_raw;
        FULL_N <= fall_through_mode ? next_ff : ~next_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Partial flags, unbuffered; almost flags timed per the strap, half-full on any edge
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALMOST_EMPTY_N <= 1'b0;
      ALMOST_FULL_N <= 1'b1;
      HALF_FULL_N <= 1'b1;
    end else if (cfg_ok) begin
      if (r_edge | w_edge) begin
        HALF_FULL_N <= ~hf_raw;
      end
      if (sync_pf) begin
        if (r_edge) begin
          ALMOST_EMPTY_N <= ~ae_raw;
        end
        if (w_edge) begin
          ALMOST_FULL_N <= ~af_raw;
        end
      end else begin
        if (r_edge & ae_raw) begin
          ALMOST_EMPTY_N <= 1'b0;
        end else if (w_edge & ~ae_raw) begin
          ALMOST_EMPTY_N <= 1'b1;
        end
        if (w_edge & af_raw) begin
          ALMOST_FULL_N <= 1'b0;
        end else if (r_edge & ~af_raw) begin
          ALMOST_FULL_N <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/ffs_map.vh ***
// Purpose: Constants shared by the flag and offset logic.
// Assumes: Included by bare name from every design file under hw/.
// Notes: Widths, defaults, config codes and buffer-stage counts.
`ifndef FFS_MAP_VH
`define FFS_MAP_VH

// Word count width, holds depth plus one for the largest depth
`define FFS_CNT_W 13
`define FFS_DEPTH_DEF 13'h0100
`define FFS_ADDR_W_DEF 12
`define FFS_DATA_W 18

// Offset register width and default values per depth
`define FFS_OFS_W 12
`define FFS_OFS_256 12'h01F
`define FFS_OFS_512 12'h03F
`define FFS_OFS_BIG 12'h07F
`define FFS_DEPTH_256 13'h0100
`define FFS_DEPTH_512 13'h0200

// Register-buffer stage counts for the boundary flags
`define FFS_STG_1 2'h1
`define FFS_STG_2 2'h2
`define FFS_STG_3 2'h3

// Cycles after reset release before the strap pins are taken
`define FFS_CFG_WAIT 2'h3

`endif

// *** hw/ffs_buf2.v ***
// Purpose: Two-entry buffer with valid/ready on both sides.
// Assumes: Same clock as the producer and the consumer.
// Notes: Outputs come from the head entry flops; ready is !second.
`include "ffs_map.vh"
`default_nettype none

module ffs_buf2 #(
  parameter W = 18
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Filling side
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  // Draining side
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);

  reg [W-1:0] head;
  reg [W-1:0] tail;
  reg head_v;
  reg tail_v;
  wire push;
  wire pop;

  // Room exists while the second slot is free
  assign in_ready = ~tail_v;
  assign out_valid = head_v;
  assign out_data = head;
  assign push = in_valid & ~tail_v;
  assign pop = head_v & out_ready;

  ////////////////////////////////////////////////////////////////////////
  // Storage update, a stalled consumer fills the tail then refuses
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      head <= {W{1'b0}};
      tail <= {W{1'b0}};
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!head_v) begin
            head <= in_data;
            head_v <= 1'b1;
          end else begin
            tail <= in_data;
            tail_v <= 1'b1;
          end
        end
        2'b01: begin
          head <= tail;
          head_v <= tail_v;
          tail_v <= 1'b0;
        end
        2'b11: begin
          if (tail_v) begin
            head <= tail;
            tail <= in_data;
          end else begin
            head <= in_data;
          end
        end
        default: begin
          head_v <= head_v;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** dv/ffs_chk_assertions.sv ***
// Purpose: Timing checks on the flag and offset block outputs.
// Assumes: Pins pass two sync flops and an edge flop before use.
// Notes: Event windows of four clocks absorb pipeline doubt.
`default_nettype none

module ffs_chk #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Pins
  input wire logic WCLK_PIN,
  input wire logic RCLK_PIN,
  input wire logic OFFSET_LOAD_N,
  input wire logic FIRST_LOAD_SEL,
  // Outputs watched
  input wire logic RAM_WR_VALID,
  input wire logic [ADDR_W-1:0] RAM_RD_ADDR,
  input wire logic [17:0] DATA_OUT,
  input wire logic EMPTY_N,
  input wire logic FULL_N,
  input wire logic ALMOST_EMPTY_N,
  input wire logic ALMOST_FULL_N,
  input wire logic HALF_FULL_N,
  input wire logic FALL_THROUGH_MODE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] ws, rs, wh, rh;
  logic [1:0] ls;
  logic wev, rev, wr, rr, ft;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////
  // Rebuild pin events as the block sees them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ws <= 3'h0;
      rs <= 3'h0;
      wh <= 3'h0;
      rh <= 3'h0;
      ls <= 2'h3;
    end else begin
      ws <= {ws[1:0], WCLK_PIN};
      rs <= {rs[1:0], RCLK_PIN};
      wh <= {wh[1:0], wev};
      rh <= {rh[1:0], rev};
      ls <= {ls[0], OFFSET_LOAD_N};
    end
  end
  // Exact cycle is unknown here, so a short window is accepted
  assign wev = ws[1] & ~ws[2];
  assign rev = rs[1] & ~rs[2];
  assign wr = wev | (|wh);
  assign rr = rev | (|rh);
  assign ft = FALL_THROUGH_MODE;

  ////////////////////////////////////////////////////////////////////////
  sequence s_ld_read;
    !ls[1] && rev;
  endsequence
  sequence s_ld_write;
    !ls[1] && wev;
  endsequence

  chk_data_on_read: assert property ($changed(DATA_OUT) |-> rr)
    else $error("Output word moved without a read event");
  chk_rdbk_no_pop: assert property (
    s_ld_read |=> $stable(RAM_RD_ADDR) [*4])
    else $error("Readback moved the read pointer");
  chk_load_no_word: assert property (
    s_ld_write |=> !$rose(RAM_WR_VALID) [*4])
    else $error("Offset load wrote a word");
  chk_fall_through_mode_no_rdbk: assert property (
    ft ##0 s_ld_read |=> $stable(DATA_OUT) [*4])
    else $error("Readback shown in fall-through mode");
  chk_ae_set_read: assert property ($fell(ALMOST_EMPTY_N) |-> rr)
    else $error("Almost-empty set without a read event");
  chk_ae_clear_side: assert property (
    $rose(ALMOST_EMPTY_N) |-> (FIRST_LOAD_SEL ? rr : wr))
    else $error("Almost-empty cleared on the wrong side");
  chk_af_set_write: assert property ($fell(ALMOST_FULL_N) |-> wr)
    else $error("Almost-full set without a write event");
  chk_af_clear_side: assert property (
    $rose(ALMOST_FULL_N) |-> (FIRST_LOAD_SEL ? wr : rr))
    else $error("Almost-full cleared on the wrong side");
  chk_empty_read_side: assert property (
    !ft && $changed(EMPTY_N) |-> rr)
    else $error("Empty flag moved without a read event");
  chk_full_write_side: assert property (
    !ft && $changed(FULL_N) |-> wr)
    else $error("Full flag moved without a write event");
  chk_half_on_event: assert property (
    $changed(HALF_FULL_N) |-> wr || rr)
    else $error("Half-full moved without an event");
endmodule

bind ffs_flag_core ffs_chk #(.ADDR_W(ADDR_W)) u_ffs_chk (
  .CLK(CLK), .RST_N(RST_N), .WCLK_PIN(WCLK_PIN), .RCLK_PIN(RCLK_PIN),
  .OFFSET_LOAD_N(OFFSET_LOAD_N), .FIRST_LOAD_SEL(FIRST_LOAD_SEL),
  .RAM_WR_VALID(RAM_WR_VALID), .RAM_RD_ADDR(RAM_RD_ADDR),
  .DATA_OUT(DATA_OUT), .EMPTY_N(EMPTY_N), .FULL_N(FULL_N),
  .ALMOST_EMPTY_N(ALMOST_EMPTY_N), .ALMOST_FULL_N(ALMOST_FULL_N),
  .HALF_FULL_N(HALF_FULL_N), .FALL_THROUGH_MODE(FALL_THROUGH_MODE));
`default_nettype wire

// *** dv/ffs_ram_model.sv ***
// Purpose: Memory behind the flag block.
// Assumes: One clock; words land in arrival order.
// Notes: With stall set, two cycles in four are refused.
`default_nettype none

module ffs_ram_model #(
  parameter [12:0] DEPTH = 13'h0100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic stall,
  // Block side
  input wire logic wr_valid,
  input wire logic [17:0] wr_data,
  input wire logic [11:0] rd_addr,
  output logic wr_ready,
  output logic [17:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [17:0] mem [0:4095];
  logic [12:0] wp;
  logic [1:0] tick;

  // Slow answer exercises the two-entry buffer
  assign wr_ready = !(stall && tick[1]);
  assign rd_data = mem[rd_addr];
  // Store on valid and ready; own pointer wraps at depth
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 13'h0000;
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
      if (wr_valid && wr_ready) begin
        mem[wp[11:0]] <= wr_data;
        wp <= (wp == DEPTH - 13'h0001) ? 13'h0000 : wp + 13'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/ffs_tb.sv ***
// Purpose: Self-checking bench for the flag and offset block.
// Assumes: Pin events nine clocks apart, straps set before reset.
// Notes: Standard async, synchronous and fall-through runs.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, rst_n = 1'h0, wclk = 1'h0, wen_n = 1'h1, rclk = 1'h0;
  logic ren_n = 1'h1, ld_n = 1'h1, fl = 1'h0, read_chain_in = 1'h0, write_chain_in = 1'h0;
  logic stall = 1'h0, ram_rdy, ram_val, ft, ef, ff, ae, af, hf;
  logic [17:0] din = 18'h00000, ram_rd, ram_wd, dout;
  logic [11:0] raddr;
  int n_mismatch = 0, tests_run = 0, cyc = 0, w = 0, f = 0, n = 31;
  int m = 31, d = 256;

  ffs_flag_core u_ffs_flag_core (.CLK(clk), .RST_N(rst_n), .WCLK_PIN(wclk),
    .WRITE_EN_N(wen_n), .DATA_IN(din), .RCLK_PIN(rclk), .READ_EN_N(ren_n),
    .OFFSET_LOAD_N(ld_n), .FIRST_LOAD_SEL(fl), .READ_CHAIN_IN(read_chain_in),
    .WRITE_CHAIN_IN(write_chain_in), .RAM_WR_READY(ram_rdy), .RAM_RD_DATA(ram_rd),
    .RAM_WR_VALID(ram_val), .RAM_WR_DATA(ram_wd), .RAM_RD_ADDR(raddr),
    .DATA_OUT(dout), .EMPTY_N(ef), .FULL_N(ff), .ALMOST_EMPTY_N(ae),
    .ALMOST_FULL_N(af), .HALF_FULL_N(hf), .FALL_THROUGH_MODE(ft));
  ffs_ram_model u_ffs_ram_model (.clk(clk), .rst_n(rst_n), .stall(stall),
    .wr_valid(ram_val), .wr_data(ram_wd), .rd_addr(raddr),
    .wr_ready(ram_rdy), .rd_data(ram_rd));

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(string what, logic [17:0] exp, logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Straps held steady through release, as configuration needs
  task automatic reset(bit s, bit r, bit x);
    @(negedge clk);
    rst_n = 1'h0;
    fl = s;
    read_chain_in = r;
    write_chain_in = x;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    w = 0;
    f = x & !r;
    n = 31;
    m = 31;
  endtask

  // One pin event; strobes ride with the rising pin
  task automatic ev(bit wr, bit en, bit ld, logic [17:0] dv);
    @(negedge clk);
    ld_n = ld;
    din = dv;
    if (wr) begin
      wen_n = en;
      wclk = 1'h1;
    end else begin
      ren_n = en;
      rclk = 1'h1;
    end
    repeat (4) @(negedge clk);
    wclk = 1'h0;
    rclk = 1'h0;
    repeat (4) @(negedge clk);
    wen_n = 1'h1;
    ren_n = 1'h1;
    ld_n = 1'h1;
  endtask

  function automatic logic [17:0] word(int i);
    return 18'h15000 + 18'(i);
  endfunction

  task automatic wr1();
    ev(1, 0, 1, word(w + 1));
    w++;
  endtask

  // Partial flags against the stored count
  task automatic cf();
    cmp("half_full", w < d / 2 + 1 + f, hf);
    cmp("almost_empty", w > n + f, ae);
    cmp("almost_full", w < d + f - m, af);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    reset(0, 0, 0);
    cmp("data_out", 18'h00000, dout);
    cmp("empty", 1'h0, ef);
    cmp("full", 1'h1, ff);
    cf();
    ev(0, 0, 0, 18'h00000);
    cmp("empty_ofs", 18'h0001F, dout);
    ev(0, 0, 0, 18'h00000);
    cmp("full_ofs", 18'h0001F, dout);
    $display("test defaults done");
  endtask

  task automatic t_offsets();
    ev(1, 0, 0, 18'h00005);
    ev(1, 0, 0, 18'h00009);
    ev(1, 0, 0, 18'h3F007);
    ev(1, 1, 1, 18'h00000);
    ev(1, 0, 0, 18'h0000A);
    ev(0, 0, 0, 18'h00000);
    cmp("empty_ofs", 18'h00007, dout);
    ev(0, 0, 0, 18'h00000);
    cmp("full_ofs", 18'h0000A, dout);
    cmp("rd_addr", 12'h000, raddr);
    cmp("ram_valid", 1'h0, ram_val);
    cmp("ram_wp", 18'h00000, 18'(u_ffs_ram_model.wp));
    cmp("empty", 1'h0, ef);
    n = 7;
    m = 10;
    $display("test offsets done");
  endtask

  task automatic t_fill_drain();
    stall = 1'h1;
    repeat (256) begin
      wr1();
      cf();
      cmp("full", w < d, ff);
    end
    ev(1, 0, 1, word(999));
    cmp("full", 1'h0, ff);
    for (int i = 1; i <= 256; i++) begin
      ev(0, 0, 1, 18'h00000);
      w--;
      cmp("data_out", word(i), dout);
      cmp("empty", w != 0, ef);
      cf();
    end
    cmp("rd_addr", 12'h000, raddr);
    stall = 1'h0;
    $display("test fill_drain done");
  endtask

  task automatic t_sync();
    reset(1, 0, 0);
    repeat (32) wr1();
    cmp("almost_empty", 1'h0, ae);
    ev(0, 1, 1, 18'h00000);
    cmp("almost_empty", 1'h1, ae);
    repeat (192) wr1();
    cmp("almost_full", 1'h1, af);
    wr1();
    cmp("almost_full", 1'h0, af);
    ev(0, 0, 1, 18'h00000);
    cmp("almost_full", 1'h0, af);
    ev(1, 1, 1, 18'h00000);
    cmp("almost_full", 1'h1, af);
    $display("test sync done");
  endtask

  // Double buffering: the empty flag trails by one read event
  task automatic t_double();
    reset(0, 1, 0);
    cmp("fall_through", 1'h0, ft);
    wr1();
    ev(0, 1, 1, 18'h00000);
    cmp("empty", 1'h0, ef);
    ev(0, 1, 1, 18'h00000);
    cmp("empty", 1'h1, ef);
    ev(0, 0, 1, 18'h00000);
    cmp("data_out", word(1), dout);
    cmp("empty", 1'h1, ef);
    ev(0, 1, 1, 18'h00000);
    cmp("empty", 1'h0, ef);
    $display("test double done");
  endtask

  task automatic t_fall_through_mode();
    reset(0, 0, 1);
    cmp("fall_through", 1'h1, ft);
    repeat (3) ev(0, 1, 1, 18'h00000);
    cmp("out_ready", 1'h1, ef);
    wr1();
    repeat (2) ev(0, 1, 1, 18'h00000);
    cmp("out_ready", 1'h1, ef);
    ev(0, 1, 1, 18'h00000);
    cmp("out_ready", 1'h0, ef);
    ev(0, 0, 0, 18'h00000);
    cmp("data_out", 18'h00000, dout);
    repeat (256) begin
      wr1();
      cf();
    end
    cmp("in_accept", 1'h0, ff);
    ev(1, 1, 1, 18'h00000);
    cmp("in_accept", 1'h1, ff);
    $display("test fall_through_mode done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    t_defaults();
    t_offsets();
    t_fill_drain();
    t_sync();
    t_double();
    t_fall_through_mode();
    complete_run();
  end
endmodule
`default_nettype wire
